// >>> design/tsc_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 100 MHz mclk; byte-wide register port from the two-wire bus engine
// Notes:   Definitions only
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// Register offsets
`define TSC_ADDR_TEMP_HIGH      8'h00
`define TSC_ADDR_STATUS         8'h01
`define TSC_ADDR_TEMP_LOW       8'h02
`define TSC_ADDR_CONFIG         8'h03
`define TSC_ADDR_RATE           8'h04
`define TSC_ADDR_SINGLE_SHOT    8'h0f
`define TSC_ADDR_OT_LIMIT       8'h20
`define TSC_ADDR_OT_HYST        8'h21
`define TSC_ADDR_BUS_TIMEOUT    8'h22
`define TSC_ADDR_VARIANT_ID     8'hfd
`define TSC_ADDR_MAKER_ID       8'hfe
`define TSC_ADDR_REVISION       8'hff

// Reset values
`define TSC_RST_CONFIG          8'h00
`define TSC_RST_RATE            8'h04
`define TSC_RST_OT_LIMIT        8'h55
`define TSC_RST_OT_HYST         8'h0a
`define TSC_RST_BUS_TIMEOUT     8'h80

// Writable bit masks; all other bits read as zero
`define TSC_CONFIG_WMASK        8'hcc
`define TSC_RATE_WMASK          8'h0f
`define TSC_TIMEOUT_WMASK       8'h80

// Field positions
`define TSC_CFG_ALERT_MASK      7
`define TSC_CFG_STANDBY         6
`define TSC_CFG_RES_HI          3
`define TSC_CFG_RES_LO          2
`define TSC_TMO_ENABLE          7
`define TSC_STAT_BUSY           7
`define TSC_STAT_OT_FLAG        0

// Resolution codes
`define TSC_RES_10BIT           2'b00
`define TSC_RES_11BIT           2'b01
`define TSC_RES_9BIT            2'b10
`define TSC_RES_12BIT           2'b11

// Highest legal rate code (32 per second)
`define TSC_RATE_MAX_CODE       4'h9

// Timing: code 0 is one conversion every 16 s
`define TSC_CLK_HZ              64'd100000000
`define TSC_SLOW_PERIOD_S       64'd16
`define TSC_SLOW_CYCLES         32'((`TSC_SLOW_PERIOD_S) * (`TSC_CLK_HZ))

// Strap sampling delay after reset release, in cycles
`define TSC_STRAP_DELAY         2'd3

`endif

// >>> design/tsc_pkg.sv
// Purpose: Types shared by the conversion control block
// Assumes: Constants live in tsc_map.svh
// Notes:   One-hot converter sequencer states
package tsc_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } tsc_reg_req_t;

   typedef struct packed {
      logic [11:0] temp;       // Two's complement, 1/16 degree per LSB
      logic        outOfLimit; // High/low limit comparison of this sample
   } tsc_sample_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } tsc_state_t;

endpackage : tsc_pkg

// >>> design/tsc_conversion_control.sv
// Purpose: Conversion control, limit and identification logic of a temperature sensor
// Assumes: Bus engine on mclk presents decoded byte reads and writes; converter on mclk
// Notes:   Pins are open drain: the *Oe outputs pull the line low when high
//
// How it works
// - Alert mask bit 7 gates alert pin
// - Standby bit 6 stops rate-timed conversions
// - Registers stay accessible during standby
// - Bits 3:2 choose 9 to 12 bit width
// - Rate code 0..9 doubles from 1/16 Hz
// - Rate register resets to code 4
// - Standby single-shot write runs one conversion
// - Busy bit high throughout every conversion
// - Single-shot data byte is ignored
// - Single-shot ignored in continuous mode
// - Overtemp limit signed byte, reset 85
// - Overtemp pin low when temperature above limit
// - Release below limit minus hysteresis, reset 10
// - Timeout enable bit 7, reset enabled
// - Read-only variant identifier
// - Read-only maker identifier
// - Read-only silicon revision
// - Low byte hides bits beyond resolution
// - Overtemp compare uses integer byte only
// - Alert latched until alert response acknowledged
// - Status flag mirrors overtemp pin state
`include "tsc_map.svh"

module tsc_conversion_control #(
   parameter logic [31:0] SLOW_PERIOD = `TSC_SLOW_CYCLES,
   parameter logic [7:0]  VARIANT_ID  = 8'ha5, // Arbitrary value
   parameter logic [7:0]  MAKER_ID    = 8'h5a, // Arbitrary value
   parameter logic [7:0]  SILICON_REVISION = 8'h3c  // Arbitrary value
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   // Register port from the two-wire bus engine
   input  wire logic                 regWrite,
   input  wire tsc_pkg::tsc_reg_req_t regWrReq,
   input  wire logic                 regRead,
   input  wire logic [7:0]           regRdAddr,
   output logic [7:0]                rdData,
   output logic                      rdValid,
   output logic                      busTimeoutEn,
   // Alert response acknowledged with own address
   input  wire logic                 araAck,
   // Converter
   output logic                      convStart,
   output logic [1:0]                convResolution,
   output logic                      convStandby,
   input  wire logic                 convDone,
   input  wire tsc_pkg::tsc_sample_t convSample,
   // Open-drain alert pin
   output logic                      alertOut,
   output logic                      alertOe,
   // Open-drain overtemp pin, also an address strap at power-up
   input  wire logic                 otPinIn,
   output logic                      otOut,
   output logic                      otOe,
   output logic                      addrStrap
);
   import tsc_pkg::*;

   // Register file
   logic [7:0] cfgReg;
   logic [7:0] rateReg;
   logic [7:0] otLimit;
   logic [7:0] otHyst;
   logic [7:0] tmoReg;
   logic [7:0] next_cfgReg;
   logic [7:0] next_rateReg;
   logic [7:0] next_otLimit;
   logic [7:0] next_otHyst;
   logic [7:0] next_tmoReg;
   logic       shotWrite;

   // Sequencer and rate timer
   tsc_state_t state;
   tsc_state_t next_state;
   logic [31:0] timer;
   logic [31:0] next_timer;
   logic [31:0] reloadValue;
   logic [3:0]  effRate;
   logic        next_convStart;
   logic        standby;
   logic        sampleDone;

   // Measured temperature and flags
   logic [11:0] tempReg;
   logic [11:0] next_tempReg;
   logic        otFlag;
   logic        next_otFlag;
   logic        alertLatch;
   logic        next_alertLatch;
   logic signed [9:0] tempInt;
   logic signed [9:0] limitS;
   logic signed [9:0] releaseLevel;
   logic [3:0]  fracMask;

   // Read data
   logic [7:0]  next_rdData;
   logic        next_rdValid;

   // Strap capture
   logic        otSync1;
   logic        otSync2;
   logic [1:0]  strapCnt;
   logic        strapDone;
   logic        next_addrStrap;
   logic [1:0]  next_strapCnt;
   logic        next_strapDone;

   assign standby   = cfgReg[`TSC_CFG_STANDBY];
   assign shotWrite = regWrite && (regWrReq.addr == `TSC_ADDR_SINGLE_SHOT);

   // Register writes; identifier and status addresses fall through untouched
   always_comb begin
      next_cfgReg  = cfgReg;
      next_rateReg = rateReg;
      next_otLimit = otLimit;
      next_otHyst  = otHyst;
      next_tmoReg  = tmoReg;
      if (regWrite) begin
         unique case (regWrReq.addr)
            `TSC_ADDR_CONFIG: begin
               // Bit 5 and reserved bits read back as zero
               next_cfgReg = regWrReq.data & `TSC_CONFIG_WMASK;
            end
            `TSC_ADDR_RATE: begin
               next_rateReg = regWrReq.data & `TSC_RATE_WMASK;
            end
            `TSC_ADDR_OT_LIMIT: begin
               next_otLimit = regWrReq.data;
            end
            `TSC_ADDR_OT_HYST: begin
               next_otHyst = regWrReq.data;
            end
            `TSC_ADDR_BUS_TIMEOUT: begin
               next_tmoReg = regWrReq.data & `TSC_TIMEOUT_WMASK;
            end
            default: begin
               // Identifiers, status, temperature and single-shot store nothing
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cfgReg  <= `TSC_RST_CONFIG;
         rateReg <= `TSC_RST_RATE;
         otLimit <= `TSC_RST_OT_LIMIT;
         otHyst  <= `TSC_RST_OT_HYST;
         tmoReg  <= `TSC_RST_BUS_TIMEOUT;
      end else begin
         cfgReg  <= next_cfgReg;
         rateReg <= next_rateReg;
         otLimit <= next_otLimit;
         otHyst  <= next_otHyst;
         tmoReg  <= next_tmoReg;
      end
   end

   // Reserved codes behave like code 0 rather than an undefined period
   assign effRate     = (rateReg[3:0] > `TSC_RATE_MAX_CODE) ? 4'h0 : rateReg[3:0];
   assign reloadValue = SLOW_PERIOD >> effRate;
   assign sampleDone  = (state == ST_CONV) && convDone;

   // Sequencer: idle until the rate timer or a single-shot asks for a sample
   always_comb begin
      next_state     = state;
      next_timer     = timer;
      next_convStart = 1'b0;
      if (standby) begin
         // Timer parked at a full period so leaving standby waits one period
         next_timer = reloadValue;
      end else if (timer > 32'd1) begin
         next_timer = timer - 32'd1;
      end
      unique case (state)
         ST_IDLE: begin
            if (!standby && timer <= 32'd1) begin
               next_state     = ST_CONV;
               next_convStart = 1'b1;
               next_timer     = reloadValue;
            end else if (standby && shotWrite) begin
               next_state     = ST_CONV;
               next_convStart = 1'b1;
            end
         end
         ST_CONV: begin
            // A shot written mid-conversion is dropped; one sample per request
            if (convDone) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state     <= ST_IDLE;
         timer     <= 32'd1;
         convStart <= 1'b0;
      end else begin
         state     <= next_state;
         timer     <= next_timer;
         convStart <= next_convStart;
      end
   end

   assign convResolution = cfgReg[`TSC_CFG_RES_HI:`TSC_CFG_RES_LO];
   // In standby the converter stays powered down unless a sample is in flight
   assign convStandby    = standby && (state == ST_IDLE);

   // Fraction bits kept for each resolution
   always_comb begin
      unique case (convResolution)
         `TSC_RES_9BIT:  fracMask = 4'h8;
         `TSC_RES_10BIT: fracMask = 4'hc;
         `TSC_RES_11BIT: fracMask = 4'he;
         `TSC_RES_12BIT: fracMask = 4'hf;
      endcase
   end

   // Integer byte only; widened so limit minus hysteresis cannot wrap
   assign tempInt      = 10'(signed'(convSample.temp[11:4]));
   assign limitS       = 10'(signed'(otLimit));
   assign releaseLevel = limitS - 10'(signed'(otHyst));

   // Flags update on each completed sample
   always_comb begin
      next_tempReg    = tempReg;
      next_otFlag     = otFlag;
      next_alertLatch = alertLatch;
      if (araAck) begin
         next_alertLatch = 1'b0;
      end
      if (sampleDone) begin
         next_tempReg = {convSample.temp[11:4], convSample.temp[3:0] & fracMask};
         if (tempInt > limitS) begin
            next_otFlag = 1'b1;
         end else if (tempInt < releaseLevel) begin
            next_otFlag = 1'b0;
         end
         // Set wins over an acknowledge in the same cycle
         if (convSample.outOfLimit && !cfgReg[`TSC_CFG_ALERT_MASK]) begin
            next_alertLatch = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tempReg    <= 12'h000;
         otFlag     <= 1'b0;
         alertLatch <= 1'b0;
      end else begin
         tempReg    <= next_tempReg;
         otFlag     <= next_otFlag;
         alertLatch <= next_alertLatch;
      end
   end

   // Register reads, answered one cycle after the strobe
   always_comb begin
      next_rdValid = regRead;
      next_rdData  = rdData;
      if (regRead) begin
         unique case (regRdAddr)
            `TSC_ADDR_TEMP_HIGH:   next_rdData = tempReg[11:4];
            `TSC_ADDR_TEMP_LOW:    next_rdData = {tempReg[3:0], 4'h0};
            `TSC_ADDR_STATUS: begin
               next_rdData                   = 8'h00;
               next_rdData[`TSC_STAT_BUSY]   = (state == ST_CONV);
               next_rdData[`TSC_STAT_OT_FLAG] = otFlag;
            end
            `TSC_ADDR_CONFIG:      next_rdData = cfgReg;
            `TSC_ADDR_RATE:        next_rdData = rateReg;
            `TSC_ADDR_OT_LIMIT:    next_rdData = otLimit;
            `TSC_ADDR_OT_HYST:     next_rdData = otHyst;
            `TSC_ADDR_BUS_TIMEOUT: next_rdData = tmoReg;
            `TSC_ADDR_VARIANT_ID:  next_rdData = VARIANT_ID;
            `TSC_ADDR_MAKER_ID:    next_rdData = MAKER_ID;
            `TSC_ADDR_REVISION:    next_rdData = SILICON_REVISION;
            default:               next_rdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdData  <= 8'h00;
         rdValid <= 1'b0;
      end else begin
         rdData  <= next_rdData;
         rdValid <= next_rdValid;
      end
   end

   assign busTimeoutEn = tmoReg[`TSC_TMO_ENABLE];

   // Open-drain drives: value always low, enable pulls the line
   assign alertOut = 1'b0;
   assign alertOe  = alertLatch && !cfgReg[`TSC_CFG_ALERT_MASK];
   assign otOut    = 1'b0;
   assign otOe     = otFlag;

   // Strap: the pin is only sensed before the overtemp drive can engage
   always_comb begin
      next_strapCnt  = strapCnt;
      next_strapDone = strapDone;
      next_addrStrap = addrStrap;
      if (!strapDone) begin
         if (strapCnt == `TSC_STRAP_DELAY) begin
            next_strapDone = 1'b1;
            next_addrStrap = otSync2;
         end else begin
            next_strapCnt = strapCnt + 2'd1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      otSync1 <= otPinIn;
      otSync2 <= otSync1;
      if (!rstn) begin
         strapCnt  <= 2'd0;
         strapDone <= 1'b0;
         addrStrap <= 1'b0;
      end else begin
         strapCnt  <= next_strapCnt;
         strapDone <= next_strapDone;
         addrStrap <= next_addrStrap;
      end
   end

endmodule // tsc_conversion_control

// >>> tb/tsc_conversion_control_sva.sv
// Purpose: Port-level assertions for conversion control
// Assumes: Bound to tsc_conversion_control, one clock domain
// Notes:   Limit values are internal, so pin checks tie changes to causes
`include "tsc_map.svh"
module tsc_conversion_control_sva (
   // Clock and reset
   input wire logic                  mclk,
   input wire logic                  rstn,
   // Register port
   input wire logic                  regWrite,
   input wire tsc_pkg::tsc_reg_req_t regWrReq,
   input wire logic                  regRead,
   input wire logic                  rdValid,
   input wire logic                  busTimeoutEn,
   // Converter and pins
   input wire logic                  araAck,
   input wire logic                  convStart,
   input wire logic [1:0]            convResolution,
   input wire logic                  convStandby,
   input wire logic                  convDone,
   input wire logic                  alertOe,
   input wire logic                  otOe
);
   timeunit 1ns;
   timeprecision 1ps;
   import tsc_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic cfgWr, tmoWr;
   assign cfgWr = regWrite && regWrReq.addr == `TSC_ADDR_CONFIG;
   assign tmoWr = regWrite && regWrReq.addr == `TSC_ADDR_BUS_TIMEOUT;
   sequence s_shot_req;
      regWrite && regWrReq.addr == `TSC_ADDR_SINGLE_SHOT && convStandby;
   endsequence
   sequence s_conv_begin;
      convStart ##1 !convStart && !convStandby;
   endsequence
   a_shot_starts: assert property (s_shot_req |=> s_conv_begin)
      else $error("standby shot write did not start a conversion");
   a_start_pulse: assert property (convStart |=> !convStart)
      else $error("start longer than one cycle");
   a_standby_quiet: assert property (convStandby |-> !convStart)
      else $error("start while in standby");
   a_read_answer: assert property (regRead |=> rdValid)
      else $error("read not answered next cycle");
   a_no_stray_valid: assert property (!regRead |=> !rdValid)
      else $error("read valid without read");
   a_ot_holds: assert property (!convDone |=> $stable(otOe))
      else $error("overtemp pin moved without a sample");
   a_alert_rise: assert property (!convDone && !cfgWr |=> !$rose(alertOe))
      else $error("alert rose without a sample");
   a_alert_ack: assert property (araAck && !convDone |=> !alertOe)
      else $error("alert kept after acknowledge");
   a_mask_forces: assert property (cfgWr && regWrReq.data[7] |=> !alertOe)
      else $error("masked alert still driven");
   a_res_hold: assert property (!cfgWr |=> $stable(convResolution))
      else $error("resolution changed without write");
   a_tmo_follow: assert property (tmoWr |=> busTimeoutEn == $past(regWrReq.data[7]))
      else $error("timeout enable not taken from write");
endmodule // tsc_conversion_control_sva

// >>> tb/tsc_converter_model.sv
// Purpose: Behavioural converter facing the control block
// Assumes: One conversion per start, lat cycles long
// Notes:   Sample lines toggle outside the done cycle
module tsc_converter_model import tsc_pkg::*; (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   // Control
   input  wire logic                 convStart,
   input  wire logic [3:0]           lat,
   input  wire tsc_pkg::tsc_sample_t sampleIn,
   // Result
   output logic                      convDone,
   output tsc_pkg::tsc_sample_t      convSample
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt = 4'h0;
   initial convDone = 1'b0;
   initial convSample = '0;
   always @(posedge mclk) begin
      convDone <= 1'b0;
      convSample <= ~convSample; // Stale data must never look valid
      if (!rstn)
         cnt <= 4'h0;
      else if (convStart)
         cnt <= lat;
      else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
         convDone <= cnt == 4'h1;
         if (cnt == 4'h1)
            convSample <= sampleIn;
      end
   end
endmodule // tsc_converter_model

// >>> tb/tsc_conversion_control_tb.sv
// Purpose: Self-checking bench for tsc_conversion_control
// Assumes: Slow period shortened to 1024 cycles
// Notes:   Every bus access takes two edges
`include "tsc_map.svh"
module tsc_conversion_control_tb import tsc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CFG = `TSC_ADDR_CONFIG;
   localparam logic [7:0] SHOT = `TSC_ADDR_SINGLE_SHOT;
   localparam logic [7:0] STAT = `TSC_ADDR_STATUS;
   localparam logic [7:0] VID = 8'h96; // Arbitrary value
   localparam logic [7:0] MID = 8'h69; // Arbitrary value
   localparam logic [7:0] RID = 8'h17; // Arbitrary value
   logic mclk = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0, araAck = 1'b0;
   logic expOt = 1'b0;
   logic [7:0] regRdAddr = 8'h00, d, rdData;
   logic [1:0] res = 2'b00, convResolution;
   logic [3:0] lat = 4'h4;
   tsc_reg_req_t regWrReq = '0;
   tsc_sample_t sampleIn = '0, convSample;
   logic rdValid, busTimeoutEn, convStart, convStandby, convDone, alertOe, otOe;
   logic alertOut, otOut, addrStrap;
   wire otPinIn = !otOe; // Pull-up on the pin
   int fails = 0, numChecks = 0, cycles = 0, n;
   integer seed = 32'hdfdf33e9;
   logic [7:0] ad[9] = '{CFG, 8'h04, 8'h20, 8'h21, 8'h22, 8'hfd, 8'hfe, 8'hff, 8'h10};
   logic [7:0] rv[9] = '{8'h00, 8'h04, 8'h55, 8'h0a, 8'h80, VID, MID, RID, 8'h00};
   logic [7:0] wm[9] = '{8'hcc, 8'h0f, 8'hff, 8'hff, 8'h80, 8'h0, 8'h0, 8'h0, 8'h0};
   // Last entry is negative: an unsigned compare would wrongly set the flag
   logic [11:0] otT[5] = '{12'h55f, 12'h560, 12'h4b0, 12'h4a0, 12'hc00};
   logic [3:0] codes[5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'hc};
   tsc_conversion_control #(.SLOW_PERIOD(32'd1024), .VARIANT_ID(VID), .MAKER_ID(MID),
      .SILICON_REVISION(RID)) i_dut (.mclk(mclk), .rstn(rstn), .regWrite(regWrite),
      .regWrReq(regWrReq), .regRead(regRead), .regRdAddr(regRdAddr), .rdData(rdData),
      .rdValid(rdValid), .busTimeoutEn(busTimeoutEn), .araAck(araAck),
      .convStart(convStart), .convResolution(convResolution), .convStandby(convStandby),
      .convDone(convDone), .convSample(convSample), .alertOut(alertOut), .alertOe(alertOe),
      .otPinIn(otPinIn), .otOut(otOut), .otOe(otOe), .addrStrap(addrStrap));
   tsc_converter_model i_conv (.mclk(mclk), .rstn(rstn), .convStart(convStart),
      .lat(lat), .sampleIn(sampleIn), .convDone(convDone), .convSample(convSample));
   always #5 mclk = ~mclk;
   function automatic logic otNext(logic cur, logic [7:0] hi);
      if ($signed(hi) > $signed(8'h55)) return 1'b1;
      if ($signed(hi) < $signed(8'h55 - 8'h0a)) return 1'b0;
      return cur;
   endfunction
   function automatic logic [7:0] lowExp(logic [3:0] f, logic [1:0] r);
      case (r)
         2'b10: return {f & 4'h8, 4'h0};
         2'b00: return {f & 4'hc, 4'h0};
         2'b01: return {f & 4'he, 4'h0};
         default: return {f, 4'h0};
      endcase
   endfunction
   function automatic int period(logic [3:0] c);
      return c > 4'h9 ? 1024 : 1024 >> c;
   endfunction
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic tick;
      @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, exp);
      numChecks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, v);
      regWrite = 1'b1;
      regWrReq = '{addr: a, data: v};
      tick;
      regWrite = 1'b0;
      tick;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      regRead = 1'b1;
      regRdAddr = a;
      tick;
      regRead = 1'b0;
      chk(rdValid, 1'b1);
      chk(rdData, exp);
      tick;
   endtask
   task automatic await(input logic done);
      n = 0;
      while ((done ? convDone : convStart) !== 1'b1 && n < 4000) begin
         tick;
         n++;
      end
   endtask
   task automatic shot(input logic [11:0] t, input logic ool);
      sampleIn = '{temp: t, outOfLimit: ool};
      wr(SHOT, 8'($random(seed)));
      rd(STAT, {1'b1, 6'h0, expOt});
      await(1'b1);
      tick;
      expOt = otNext(expOt, t[11:4]);
      chk(otOe, expOt);
      rd(STAT, {7'h00, expOt});
      rd(8'h00, t[11:4]);
      rd(8'h02, lowExp(t[3:0], res));
   endtask
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         report_and_stop;
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      #1;
      rstn = 1'b1;
      chk(busTimeoutEn, 1'b1);
      chk(convResolution, 2'b00);
      foreach (ad[i]) begin
         rd(ad[i], rv[i]);
         d = 8'($random(seed)) & 8'hdf | 8'h40;
         wr(ad[i], d);
         rd(ad[i], wm[i] == 8'h00 ? rv[i] : d & wm[i]);
      end
      wr(8'h20, 8'h55);
      wr(8'h21, 8'h0a);
      // Pin drive values low; strap saw the pulled-up line
      chk({alertOut, otOut, addrStrap}, 3'b001);
      for (int r = 0; r < 4; r++) begin
         res = 2'(r);
         wr(CFG, {4'h4, res, 2'h0});
         chk(convResolution, res);
         chk(convStandby, 1'b1);
         shot({8'h19, 4'($random(seed))}, 1'b0);
      end
      foreach (otT[i]) shot(otT[i], 1'b0);
      shot(12'h100, 1'b1);
      chk(alertOe, 1'b1);
      araAck = 1'b1;
      tick;
      araAck = 1'b0;
      chk(alertOe, 1'b0);
      wr(CFG, 8'hc0);
      res = 2'b00;
      shot(12'h100, 1'b1);
      chk(alertOe, 1'b0);
      lat = 4'h2;
      foreach (codes[i]) begin
         wr(8'h04, {4'h0, codes[i]});
         wr(CFG, 8'h00);
         await(1'b0);
         repeat (6) tick;
         wr(SHOT, 8'h3c);
         await(1'b0);
         chk(16'(n + 8), 16'(period(codes[i])));
         wr(CFG, 8'h40);
      end
      report_and_stop;
   end
endmodule // tsc_conversion_control_tb
bind tsc_conversion_control tsc_conversion_control_sva i_sva (.mclk(mclk), .rstn(rstn),
   .regWrite(regWrite), .regWrReq(regWrReq), .regRead(regRead), .rdValid(rdValid),
   .busTimeoutEn(busTimeoutEn), .araAck(araAck), .convStart(convStart),
   .convResolution(convResolution), .convStandby(convStandby), .convDone(convDone),
   .alertOe(alertOe), .otOe(otOe));
